// [hw/flash_spi_pkg.sv]
// Constants, pin indexes and state codes for the serial flash front end
package flash_spi_pkg;

   // ****************************************************************
   // Pin sampling
   // ****************************************************************
   localparam int SYNC_W = 5;
   localparam int PIN_SCK = 0;
   localparam int PIN_CS_N = 1;
   localparam int PIN_SI = 2;
   localparam int PIN_WP_N = 3;
   localparam int PIN_RST_N = 4;
   // Idle pin levels: select and reset high, clock low
   localparam logic [4:0] SYNC_RESET = 5'h1a;

   // ****************************************************************
   // Data path
   // ****************************************************************
   localparam int BYTE_W = 8;
   localparam int TX_FIFO_DEPTH = 8;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [7:0] IDLE_BYTE = 8'hff;

   // Output lane modes
   localparam logic [1:0] LANE_SINGLE = 2'h0;
   localparam logic [1:0] LANE_DUAL = 2'h1;
   localparam logic [1:0] LANE_QUAD = 2'h2;

   // Page sizes in bytes
   localparam logic [9:0] PAGE_BYTES_528 = 10'h210;
   localparam logic [9:0] PAGE_BYTES_512 = 10'h200;
   localparam logic PAGE_512_RESET = 1'b0;

   // ****************************************************************
   // Front end states
   // ****************************************************************
   typedef enum logic [4:0] {
      ST_IDLE = 5'b00001,
      ST_SEL = 5'b00010,
      ST_OUT = 5'b00100,
      ST_FINISH = 5'b01000,
      ST_HOLD = 5'b10000
   } state_t;

endpackage

// [hw/tx_fifo.sv]
// Small flip-flop FIFO with valid and ready on both sides
`timescale 1ns/1ns
module tx_fifo
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
)
(
   input wire logic clk,
   input wire logic srst,
   input wire logic flush,
   input wire logic in_valid,
   input wire logic [WIDTH-1:0] in_data,
   output logic in_ready,
   output logic out_valid,
   output logic [WIDTH-1:0] out_data,
   input wire logic out_ready
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   logic push;
   logic pop;

   // Flush blocks the write side so no word slips in while emptying
   assign in_ready = (count != (AW+1)'(DEPTH)) && !flush;
   assign out_valid = (count != '0);
   assign out_data = mem[rd_ptr];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready && !flush;

   // Storage write
   always_ff @(posedge clk)
   begin
      if (push)
      begin
         mem[wr_ptr] <= in_data;
      end
   end

   // Pointers and fill count
   always_ff @(posedge clk)
   begin
      if (srst || flush)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
         end
         if (pop)
         begin
            rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
         end
         if (push && !pop)
         begin
            count <= count + 1'b1;
         end
         else if (pop && !push)
         begin
            count <= count - 1'b1;
         end
      end
   end

endmodule // tx_fifo

// [hw/serial_flash_spi_frontend.sv]
// Serial flash front end: pin sampling, command input and lane output
`timescale 1ns/1ns
module serial_flash_spi_frontend
   import flash_spi_pkg::*;
#(
   parameter int FIFO_DEPTH = TX_FIFO_DEPTH
)
(
   input wire logic clk,
   input wire logic srst,
   input wire logic sck_pin,
   input wire logic cs_n_pin,
   input wire logic io0_in,
   output logic io0_out,
   output logic io0_oe,
   output logic so_out,
   output logic so_oe,
   input wire logic io2_in,
   output logic io2_out,
   output logic io2_oe,
   input wire logic io3_in,
   output logic io3_out,
   output logic io3_oe,
   output logic rx_valid,
   output logic [7:0] rx_byte,
   output logic rx_is_cmd,
   output logic frame_start,
   output logic frame_end,
   input wire logic out_start,
   input wire logic [1:0] out_lanes,
   input wire logic tx_valid,
   input wire logic [7:0] tx_data,
   output logic tx_ready,
   output logic tx_underrun,
   input wire logic quad_io_enable,
   input wire logic page_cfg_wr,
   input wire logic page_cfg_512,
   output logic [9:0] page_bytes,
   input wire logic op_busy,
   output logic standby,
   output logic selected,
   output logic write_protect
);

   // ****************************************************************
   // Lane helpers
   // ****************************************************************

   // Bits moved per falling edge in each lane mode
   function automatic logic [3:0] lane_step(input logic [1:0] lanes);
      logic [3:0] step;
      step = 4'h1;
      if (lanes == LANE_DUAL)
      begin
         step = 4'h2;
      end
      else if (lanes == LANE_QUAD)
      begin
         step = 4'h4;
      end
      return step;
   endfunction

   // Driven pins per lane mode, ordered io3, io2, so, io0
   function automatic logic [3:0] lane_oe(input logic [1:0] lanes);
      logic [3:0] mask;
      mask = 4'h2;
      if (lanes == LANE_DUAL)
      begin
         mask = 4'h3;
      end
      else if (lanes == LANE_QUAD)
      begin
         mask = 4'hf;
      end
      return mask;
   endfunction

   // ****************************************************************
   // Pin synchronisers and edge detection
   // ****************************************************************
   logic [SYNC_W-1:0] sync_a;
   logic [SYNC_W-1:0] sync_b;
   logic sck_q;
   logic cs_q;
   logic sck_s;
   logic cs_n_s;
   logic si_s;
   logic sck_rise;
   logic sck_fall;
   logic cs_fall;
   logic pin_reset;
   logic [1:0] hi_lane_hist;

   // Two stages on every pin; the first stage feeds only the second
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         sync_a <= SYNC_RESET;
         sync_b <= SYNC_RESET;
      end
      else
      begin
         sync_a <= {io3_in, io2_in, io0_in, cs_n_pin, sck_pin};
         sync_b <= sync_a;
      end
   end

   // Previous levels for edge finding
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         sck_q <= SYNC_RESET[PIN_SCK];
         cs_q <= SYNC_RESET[PIN_CS_N];
      end
      else
      begin
         sck_q <= sync_b[PIN_SCK];
         cs_q <= sync_b[PIN_CS_N];
      end
   end

   // Lines two and three echo our own quad data through the synchronisers
   // for two cycles after release; a low last nibble must not look like reset
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         hi_lane_hist <= 2'h0;
      end
      else
      begin
         hi_lane_hist <= {hi_lane_hist[0], io3_oe};
      end
   end

   assign sck_s = sync_b[PIN_SCK];
   assign cs_n_s = sync_b[PIN_CS_N];
   assign si_s = sync_b[PIN_SI];
   assign sck_rise = sck_s && !sck_q;
   assign sck_fall = !sck_s && sck_q;
   assign cs_fall = !cs_n_s && cs_q;
   // reset pin, ignored while it serves as data line three
   assign pin_reset = !sync_b[PIN_RST_N] && !io3_oe && (hi_lane_hist == 2'h0);
   // Protect pin only reads as such while not a data line
   assign write_protect = !sync_b[PIN_WP_N] && !io2_oe && (hi_lane_hist == 2'h0);

   // ****************************************************************
   // Frame state machine
   // ****************************************************************
   state_t state;
   state_t next_state;

   // Clock idle level is never inspected, so modes 0 and 3 both frame alike
   // mode independent framing
   always_comb
   begin
      next_state = state;
      case (state)
         ST_IDLE:
         begin
            // start only on a falling select
            if (cs_fall)
            begin
               next_state = ST_SEL;
            end
         end
         ST_SEL, ST_OUT:
         begin
            if (cs_n_s)
            begin
               next_state = op_busy ? ST_FINISH : ST_IDLE;
            end
            else if (state == ST_SEL && out_start)
            begin
               next_state = ST_OUT;
            end
         end
         ST_FINISH:
         begin
            if (cs_fall)
            begin
               next_state = ST_SEL;
            end
            else if (!op_busy)
            begin
               next_state = ST_IDLE;
            end
         end
         ST_HOLD:
         begin
            // Wait for a fresh select edge after the reset pin lets go
            next_state = ST_IDLE;
         end
         default:
         begin
            next_state = ST_IDLE;
         end
      endcase
      if (pin_reset)
      begin
         next_state = ST_HOLD;
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         state <= ST_IDLE;
      end
      else
      begin
         state <= next_state;
      end
   end

   // standby, never deeper, once deselected and not busy
   assign standby = (state == ST_IDLE);
   assign selected = (state == ST_SEL) || (state == ST_OUT);

   // Frame markers
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         frame_start <= 1'b0;
         frame_end <= 1'b0;
      end
      else
      begin
         frame_start <= !selected && (next_state == ST_SEL);
         frame_end <= selected && (next_state != ST_SEL) && (next_state != ST_OUT);
      end
   end

   // ****************************************************************
   // Command, address and write data input
   // ****************************************************************
   logic [2:0] rx_count;
   logic [6:0] rx_sh;
   logic rx_first;
   logic [1:0] lanes_q;
   logic rx_take;

   // line zero is an output in multi-lane reads, so no sampling then
   assign rx_take = sck_rise && (state == ST_SEL ||
                    (state == ST_OUT && lanes_q == LANE_SINGLE));

   // anything outside a frame, or a partial byte, is dropped
   always_ff @(posedge clk)
   begin
      if (srst || !selected || cs_n_s)
      begin
         rx_count <= 3'h0;
         rx_sh <= 7'h00;
         rx_first <= 1'b1;
      end
      else if (rx_take)
      begin
         rx_sh <= {rx_sh[5:0], si_s};
         rx_count <= rx_count + 3'h1;
         if (rx_count == 3'h7)
         begin
            rx_first <= 1'b0;
         end
      end
   end

   // Completed byte, first one of a frame is the command
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         rx_valid <= 1'b0;
         rx_byte <= 8'h00;
         rx_is_cmd <= 1'b0;
      end
      else
      begin
         rx_valid <= rx_take && (rx_count == 3'h7) && !cs_n_s;
         if (rx_take && (rx_count == 3'h7))
         begin
            rx_byte <= {rx_sh, si_s};
            rx_is_cmd <= rx_first;
         end
      end
   end

   // ****************************************************************
   // Configuration
   // ****************************************************************
   logic page_is_512;

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         page_is_512 <= PAGE_512_RESET;
      end
      else if (page_cfg_wr)
      begin
         page_is_512 <= page_cfg_512;
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         page_bytes <= PAGE_BYTES_528;
      end
      else
      begin
         page_bytes <= page_is_512 ? PAGE_BYTES_512 : PAGE_BYTES_528;
      end
   end

   // quad only with quad_io_enable, otherwise fall back to single
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         lanes_q <= LANE_SINGLE;
      end
      else if (state == ST_SEL && out_start)
      begin
         if (out_lanes == LANE_DUAL || (out_lanes == LANE_QUAD && quad_io_enable))
         begin
            lanes_q <= out_lanes;
         end
         else
         begin
            lanes_q <= LANE_SINGLE;
         end
      end
   end

   // ****************************************************************
   // Read data output
   // ****************************************************************
   logic fifo_valid;
   logic [7:0] fifo_data;
   logic fifo_pop;
   logic fifo_flush;
   logic [7:0] tx_sh;
   logic [3:0] bits_left;
   logic tx_started;
   logic shift_now;
   logic [7:0] word;
   logic [3:0] step;
   logic [3:0] oe_mask;

   // Stale read data never leaks into the next frame
   assign fifo_flush = !selected;
   assign shift_now = sck_fall && (state == ST_OUT) && !cs_n_s;
   assign fifo_pop = shift_now && (bits_left == 4'h0);
   assign step = lane_step(lanes_q);

   tx_fifo #(
      .WIDTH(BYTE_W),
      .DEPTH(FIFO_DEPTH)
   ) u_tx_fifo (
      .clk(clk),
      .srst(srst),
      .flush(fifo_flush),
      .in_valid(tx_valid),
      .in_data(tx_data),
      .in_ready(tx_ready),
      .out_valid(fifo_valid),
      .out_data(fifo_data),
      .out_ready(fifo_pop)
   );

   // Next byte from the FIFO once the current one is used up
   always_comb
   begin
      word = tx_sh;
      if (bits_left == 4'h0)
      begin
         word = fifo_valid ? fifo_data : IDLE_BYTE;
      end
   end

   // shift on falling clock by the lane width
   always_ff @(posedge clk)
   begin
      if (srst || !selected)
      begin
         tx_sh <= 8'h00;
         bits_left <= 4'h0;
         tx_started <= 1'b0;
      end
      else if (shift_now)
      begin
         tx_sh <= word << step;
         bits_left <= ((bits_left == 4'h0) ? BITS_PER_BYTE : bits_left) - step;
         tx_started <= 1'b1;
      end
   end

   // Pin data, highest bit on the highest driven line
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         {io3_out, io2_out, so_out, io0_out} <= 4'h0;
      end
      else if (shift_now)
      begin
         if (lanes_q == LANE_QUAD)
         begin
            {io3_out, io2_out, so_out, io0_out} <= word[7:4];
         end
         else if (lanes_q == LANE_DUAL)
         begin
            {so_out, io0_out} <= word[7:6];
         end
         else
         begin
            so_out <= word[7];
         end
      end
   end

   // Starved FIFO sends idle ones and flags it
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         tx_underrun <= 1'b0;
      end
      else
      begin
         tx_underrun <= fifo_pop && !fifo_valid;
      end
   end

   // pins driven only inside a read frame after its first fall
   assign oe_mask = (state == ST_OUT && tx_started && !cs_n_s) ? lane_oe(lanes_q) : 4'h0;
   assign {io3_oe, io2_oe, so_oe, io0_oe} = oe_mask;

endmodule // serial_flash_spi_frontend

// [tb/serial_flash_spi_frontend_sva.sv]
// Port checker for the serial flash front end
`timescale 1ns/1ns
module serial_flash_spi_frontend_sva
   import flash_spi_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic sck_pin,
   input wire logic cs_n_pin,
   input wire logic io3_in,
   input wire logic io0_oe,
   input wire logic so_out,
   input wire logic so_oe,
   input wire logic io2_oe,
   input wire logic io3_oe,
   input wire logic rx_valid,
   input wire logic frame_start,
   input wire logic frame_end,
   input wire logic quad_io_enable,
   input wire logic page_cfg_wr,
   input wire logic page_cfg_512,
   input wire logic [9:0] page_bytes,
   input wire logic op_busy,
   input wire logic standby,
   input wire logic selected
);
   // *************************
   // Port relations
   // *************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   // Release of a live frame, then six quiet cycles
   sequence s_release;
      $rose(cs_n_pin) && selected ##1 (cs_n_pin && !op_busy && io3_in)[*6];
   endsequence
   property p_standby; s_release |-> standby; endproperty
   a_standby: assert property (p_standby) else $error("no standby after release");
   property p_so_hiz; cs_n_pin[*5] |-> !so_oe; endproperty
   a_so_hiz: assert property (p_so_hiz) else $error("output driven while deselected");
   property p_no_rx; cs_n_pin[*8] |-> !rx_valid; endproperty
   a_no_rx: assert property (p_no_rx) else $error("byte taken while deselected");
   property p_start; $fell(cs_n_pin) && io3_in && !op_busy |-> ##[2:5] frame_start; endproperty
   a_start: assert property (p_start) else $error("frame start missing");
   property p_end; $rose(cs_n_pin) && selected |-> ##[2:5] frame_end; endproperty
   a_end: assert property (p_end) else $error("frame end missing");
   property p_busy; op_busy && !selected |-> !standby; endproperty
   a_busy: assert property (p_busy) else $error("standby during busy");
   // Output bits may only move after a low clock phase
   property p_fall;
      so_oe && $past(so_oe) && $changed(so_out) |-> !$past(sck_pin, 2) && !$past(sck_pin, 3);
   endproperty
   a_fall: assert property (p_fall) else $error("output moved off a falling edge");
   property p_quad; io2_oe || io3_oe |-> quad_io_enable && io0_oe && so_oe; endproperty
   a_quad: assert property (p_quad) else $error("quad lines without enable");
   property p_page;
      page_cfg_wr |-> ##[1:2] page_bytes == (page_cfg_512 ? PAGE_BYTES_512 : PAGE_BYTES_528);
   endproperty
   a_page: assert property (p_page) else $error("page size not loaded");
   property p_free; $rose(cs_n_pin) |-> ##[2:5] !(so_oe || io0_oe || io2_oe || io3_oe); endproperty
   a_free: assert property (p_free) else $error("lanes held after release");
endmodule // serial_flash_spi_frontend_sva

bind serial_flash_spi_frontend serial_flash_spi_frontend_sva u_serial_flash_spi_frontend_sva (.*);

// [tb/spi_host_model.sv]
// Behavioural SPI host driving clock, select and serial input
`timescale 1ns/1ns
module spi_host_model
(
   output logic sck,
   output logic cs_n,
   output logic si,
   input wire logic so_line,
   input wire logic io0_line,
   input wire logic io2_line,
   input wire logic io3_line
);
   // Clock starts low and select high; only the tasks move them
   initial
   begin
      sck = 1'b0;
      cs_n = 1'b1;
      si = 1'b1;
   end

   // select falls at the mode's idle level
   task automatic begin_frame(input logic m3);
      sck = m3;
      #80 cs_n = 1'b0;
      #160;
   endtask

   // input set before rise, lanes sampled late in high phase
   task automatic xfer(input logic [7:0] d, input int n, input logic [1:0] ln,
      output logic [7:0] q);
      int i;
      q = 8'h00;
      for (i = 0; i < n; i++)
      begin
         sck = 1'b0;
         si = d[7-i];
         #160 sck = 1'b1;
         // Late sample rides over the device's sync lag
         #150;
         case (ln)
            2'h1: q = {q[5:0], so_line, io0_line};
            2'h2: q = {q[3:0], io3_line, io2_line, so_line, io0_line};
            default: q = {q[6:0], so_line};
         endcase
         #10;
      end
   endtask

   // select rises with the clock at idle
   task automatic end_frame(input logic m3);
      sck = m3;
      #160 cs_n = 1'b1;
      #160;
   endtask
endmodule // spi_host_model

// [tb/serial_flash_spi_frontend_test.sv]
// Self-checking bench for the serial flash front end
`timescale 1ns/1ns
module serial_flash_spi_frontend_test;
   import flash_spi_pkg::*;
   localparam int DEPTH = 8;
   logic clk, srst, sck, cs_n, si, wp_n, rst_n, sb_on;
   logic io0_out, io0_oe, so_out, so_oe, io2_out, io2_oe, io3_out, io3_oe;
   logic rx_valid, rx_is_cmd, frame_start, frame_end, tx_ready, tx_underrun;
   logic out_start, tx_valid, quad_io_enable, page_cfg_wr, page_cfg_512, op_busy;
   logic standby, selected, write_protect;
   logic [7:0] rx_byte, tx_data, q;
   logic [1:0] out_lanes, hl;
   logic [9:0] page_bytes;
   logic [31:0] r;
   logic [15:0] exp_q[$];
   logic [7:0] rd_q[$];
   int err_count, n_compared, n_under, base, k, n, i;
   // Released lines: pull-ups on the pins, inverse on the output
   wire io0_line = io0_oe ? io0_out : si;
   wire so_line = so_oe ? so_out : !so_out;
   wire io2_line = io2_oe ? io2_out : wp_n;
   wire io3_line = io3_oe ? io3_out : rst_n;

   serial_flash_spi_frontend #(.FIFO_DEPTH(DEPTH)) u_serial_flash_spi_frontend (
      .clk(clk), .srst(srst), .sck_pin(sck), .cs_n_pin(cs_n), .io0_in(io0_line),
      .io0_out(io0_out), .io0_oe(io0_oe), .so_out(so_out), .so_oe(so_oe),
      .io2_in(io2_line), .io2_out(io2_out), .io2_oe(io2_oe), .io3_in(io3_line),
      .io3_out(io3_out), .io3_oe(io3_oe), .rx_valid(rx_valid), .rx_byte(rx_byte),
      .rx_is_cmd(rx_is_cmd), .frame_start(frame_start), .frame_end(frame_end),
      .out_start(out_start), .out_lanes(out_lanes), .tx_valid(tx_valid),
      .tx_data(tx_data), .tx_ready(tx_ready), .tx_underrun(tx_underrun),
      .quad_io_enable(quad_io_enable), .page_cfg_wr(page_cfg_wr),
      .page_cfg_512(page_cfg_512), .page_bytes(page_bytes), .op_busy(op_busy),
      .standby(standby), .selected(selected), .write_protect(write_protect));

   spi_host_model u_spi_host_model (.sck(sck), .cs_n(cs_n), .si(si), .so_line(so_line),
      .io0_line(io0_line), .io2_line(io2_line), .io3_line(io3_line));

   // 25 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         err_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic conclude;
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // Inputs move one step after the edge
   task automatic tick(input int c);
      repeat (c) @(posedge clk);
      #1;
   endtask

   // Opens a frame; full bytes leave a note, cut bytes none
   task automatic send(input logic m3, input int nd, input int cut);
      int j;
      u_spi_host_model.begin_frame(m3);
      for (j = 0; j <= nd; j++)
      begin
         r = lfsr(r);
         if (cut == 8)
            exp_q.push_back({7'h00, j == 0, r[7:0]});
         u_spi_host_model.xfer(r[7:0], cut, 2'h0, q);
      end
   endtask

   // Each received byte meets the oldest note while sb_on is set
   always @(posedge clk)
   begin
      if (tx_underrun === 1'b1)
         n_under++;
      if (rx_valid === 1'b1 && sb_on)
      begin
         if (exp_q.size() == 0)
            check({7'h00, rx_is_cmd, rx_byte}, 16'hffff);
         else
            check({7'h00, rx_is_cmd, rx_byte}, exp_q.pop_front());
      end
   end

   // Cut a hang short; the run should take about 130 us
   initial
   begin
      #1000000;
      err_count++;
      conclude;
   end

   initial
   begin
      srst = 1'b1;
      {wp_n, rst_n, sb_on} = 3'h7;
      {out_start, tx_valid, quad_io_enable, page_cfg_wr, page_cfg_512, op_busy} = 6'h00;
      out_lanes = 2'h0;
      tx_data = 8'h00;
      r = 32'hd4b806b4;
      tick(10);
      srst = 1'b0;
      tick(4);
      check(16'(page_bytes), 16'(PAGE_BYTES_528));
      check(16'({standby, so_oe}), 16'h2);
      // Page size both ways, default last
      for (k = 0; k < 2; k++)
      begin
         page_cfg_512 = (k == 0);
         page_cfg_wr = 1'b1;
         tick(1);
         page_cfg_wr = 1'b0;
         tick(2);
         check(16'(page_bytes), k ? 16'(PAGE_BYTES_528) : 16'(PAGE_BYTES_512));
      end
      wp_n = 1'b0;
      tick(5);
      check(16'(write_protect), 16'h1);
      wp_n = 1'b1;
      tick(5);
      // Clock and data wiggle with select high: nothing noted
      u_spi_host_model.xfer(8'ha5, 8, 2'h0, q);
      tick(8);
      for (k = 0; k < 2; k++)
      begin
         send(k[0], 2, 8);
         u_spi_host_model.end_frame(k[0]);
         tick(8);
      end
      // Partial byte, cut by release or by the reset pin
      for (k = 0; k < 2; k++)
      begin
         send(1'b0, 0, 5);
         rst_n = (k == 0);
         tick(8);
         check(16'({selected, standby}), k ? 16'h0 : 16'h2);
         rst_n = 1'b1;
         tick(8);
         u_spi_host_model.end_frame(1'b0);
         tick(8);
         send(1'b0, 0, 8);
         u_spi_host_model.end_frame(1'b0);
         tick(8);
      end
      send(1'b0, 0, 8);
      op_busy = 1'b1;
      u_spi_host_model.end_frame(1'b0);
      tick(8);
      check(16'(standby), 16'h0);
      op_busy = 1'b0;
      tick(6);
      check(16'(standby), 16'h1);
      // Single, dual, quad, and quad without enable falling back
      for (k = 0; k < 4; k++)
      begin
         quad_io_enable = (k != 3);
         out_lanes = (k > 1) ? 2'h2 : 2'(k);
         hl = (k == 3) ? 2'h0 : out_lanes;
         send(1'b1, 0, 8);
         tick(8);
         sb_on = 1'b0;
         n = 0;
         while (tx_ready === 1'b1 && n < 12)
         begin
            r = lfsr(r);
            tx_data = r[7:0];
            tx_valid = 1'b1;
            rd_q.push_back(r[7:0]);
            n++;
            tick(1);
         end
         tx_valid = 1'b0;
         check(16'(n), 16'(DEPTH));
         out_start = 1'b1;
         tick(1);
         out_start = 1'b0;
         base = n_under;
         for (i = 0; i <= DEPTH; i++)
         begin
            u_spi_host_model.xfer(8'hff, (hl == 2'h0) ? 8 : (hl == 2'h1) ? 4 : 2, hl, q);
            check(16'(q), (i < DEPTH) ? 16'(rd_q.pop_front()) : 16'(IDLE_BYTE));
            if (i == 0)
               check(16'({io3_oe, io2_oe, so_oe, io0_oe}), hl[1] ? 16'hf : 16'(hl) + 16'h2);
            // Host stalls mid-drain
            if (i == 3)
               #2000;
         end
         tick(6);
         check(16'(n_under - base), 16'h1);
         u_spi_host_model.end_frame(1'b1);
         tick(8);
         check(16'({io3_oe, io2_oe, so_oe, io0_oe}), 16'h0);
         sb_on = 1'b1;
      end
      check(16'(exp_q.size()), 16'h0);
      conclude;
   end
endmodule // serial_flash_spi_frontend_test
